// File: cbsc_copro_model.sv
`timescale 1ns/1ps
module cbsc_copro_model (
  input wire logic sys_clk,
  input wire logic coprocessor_reset,
  input wire logic [7:0] busy_len,
  input wire logic start,
  input wire logic fault_req,
  output logic coprocessor_active_in,
  output logic coprocessor_fault_in
);
  logic [7:0] left;
  assign coprocessor_active_in = left != 8'h00;
  always_ff @(posedge sys_clk) begin
    if (coprocessor_reset) begin
      left <= 8'h00;
      coprocessor_fault_in <= 1'b0;
    end else begin
      if (start) left <= busy_len;
      else if (left != 8'h00) left <= left - 8'h01;
      // a fault only shows in the cycle after one in which a task was running, so it can show one cycle after the task ends
      coprocessor_fault_in <= fault_req && left != 8'h00;
    end
  end
endmodule

// File: cbsc_monitor.sv
`timescale 1ns/1ps
module cbsc_monitor #(
  parameter int NP_CYC = cbsc_pkg::NP_RESET_CYC
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic [7:0] io_addr,
  input wire logic [7:0] io_wdata,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic warm_reset_req,
  input wire logic system_reset,
  input wire logic cpu_reset,
  input wire logic cpu_clock,
  input wire logic cpu_phase_clock,
  input wire logic bus_state_clock,
  input wire logic expansion_bus_clock,
  input wire logic cpu_grant,
  input wire logic dma_grant,
  input wire logic refresh_grant,
  input wire logic timer2_gate,
  input wire logic speaker_data,
  input wire logic nmi,
  input wire logic coprocessor_select,
  input wire logic coprocessor_active_in,
  input wire logic coprocessor_fault_in,
  input wire logic cpu_stall_out,
  input wire logic coprocessor_interrupt,
  input wire logic coprocessor_reset
);
  int np_cnt;
  wire logic np_hit;
  wire logic flt;
  assign np_hit = io_addr == 8'hf0 || io_addr == 8'hf1;
  assign flt = coprocessor_active_in && coprocessor_fault_in;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (srst);
  // counts the cycles a reset write still owes the coprocessor
  always_ff @(posedge sys_clk) begin
    if (srst) np_cnt <= 0;
    else if (io_wr && io_addr == 8'hf1) np_cnt <= NP_CYC;
    else if (np_cnt != 0) np_cnt <= np_cnt - 1;
  end
  sequence s_clear;
    io_wr && np_hit && !flt;
  endsequence
  sequence s_fault;
    flt && !system_reset;
  endsequence
  AST_SELECT: assert property (
    coprocessor_select == ((io_wr || io_rd) && (io_addr[7:3] == 5'h1f
    || io_addr == 8'h70 || io_addr == 8'hf0))) else $error("select");
  AST_PASS: assert property (
    coprocessor_active_in |-> cpu_stall_out) else $error("busy pass");
  AST_LATCH: assert property (
    s_fault |=> coprocessor_interrupt && cpu_stall_out) else $error("latch");
  AST_HOLD: assert property (
    coprocessor_interrupt && !system_reset && !(io_wr && np_hit)
    |=> coprocessor_interrupt) else $error("hold");
  AST_CLEAR: assert property (
    s_clear |=> !coprocessor_interrupt) else $error("clear");
  AST_SYSCLR: assert property (
    system_reset && !flt |=> !coprocessor_interrupt) else $error("sysclr");
  AST_NPRST: assert property (
    np_cnt != 0 || system_reset |-> coprocessor_reset) else $error("nprst");
  AST_COLD: assert property (
    system_reset |-> cpu_reset) else $error("cold");
  AST_WARM: assert property (
    warm_reset_req && !system_reset |=> cpu_reset && !system_reset)
    else $error("warm");
  AST_NMI_OFF: assert property (
    io_wr && io_addr == 8'h70 && io_wdata[7] |=> !nmi) else $error("nmi");
  AST_PORTB: assert property (
    io_wr && io_addr == 8'h61 |=> speaker_data == $past(io_wdata[1])
    && timer2_gate == $past(io_wdata[0])) else $error("port b");
  AST_ONEHOT: assert property (
    $onehot0({cpu_grant, dma_grant, refresh_grant})) else $error("grant");
  AST_EXPCLK: assert property (disable iff (srst || system_reset)
    $rose(bus_state_clock) |-> ##[0:1] $changed(expansion_bus_clock))
    else $error("exp clock");
  AST_PHASE: assert property (disable iff (srst || cpu_reset)
    $rose(cpu_clock) && !$past(cpu_reset) |->
    ##[0:1] $changed(cpu_phase_clock))
    else $error("phase clock");
endmodule

// File: cbsc_pkg.sv
// Behaviour
// R01 - cold start drives a long system-wide reset
// R02 - warm reset request resets the cpu only
// R03 - cpu phase clock is cpu clock halved
// R04 - expansion bus clock is bus state clock halved
// R05 - synchronous modes take both clocks from fast input
// R06 - asynchronous modes take bus clock from bus input
// R07 - three synchronous cpu and bus clock selections
// R08 - two asynchronous selections, expansion clock bus input halved
// R09 - software should run the cpu from fast input
// R10 - separate cpu and bus state machines
// R11 - arbitrate bus among cpu, dma and refresh
// R12 - port b: four status bits, four control bits
// R13 - latch enabled errors, raise nmi when enabled
// R14 - port b read shows which error caused nmi
// R15 - write to 070h bit 7 sets nmi mask
// R16 - coprocessor select for f8h-ffh, 070h and f0h
// R17 - coprocessor busy passes through as cpu stall
// R18 - fault while busy latches stall and interrupt
// R19 - write to f0h or f1h clears both latches
// R20 - system reset clears stall and interrupt latches
// R21 - coprocessor reset on system reset or f1h write
// R22 - default clocks: cpu fast, bus half fast
// R23 - clock source switching makes no runt pulses
package cbsc_pkg;
  localparam int CLK_PERIOD_NS = 20;
  localparam int COLD_RESET_NS = 2000;
  localparam int WARM_RESET_NS = 400;
  localparam int NP_RESET_NS = 200;
  localparam int COLD_RESET_CYC =
    (COLD_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WARM_RESET_CYC =
    (WARM_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int NP_RESET_CYC =
    (NP_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RST_CNT_W = 8;

  localparam logic [7:0] PORTB_ADDR = 8'h61;
  localparam logic [7:0] NMI_MASK_ADDR = 8'h70;
  localparam logic [7:0] NP_CLEAR_ADDR = 8'hf0;
  localparam logic [7:0] NP_RESET_ADDR = 8'hf1;
  localparam logic [7:0] NP_REG_BASE = 8'hf8;
  localparam logic [7:0] NP_REG_MASK = 8'hf8;
  localparam logic [7:0] CLK_CFG_ADDR = 8'h0c;
  localparam logic [7:0] STATUS_ADDR = 8'h0d;

  localparam int PB_PARITY_FLAG = 7;
  localparam int PB_CHANNEL_FLAG = 6;
  localparam int PB_TIMER2_OUT = 5;
  localparam int PB_REFRESH = 4;
  localparam int PB_CHANNEL_EN = 3;
  localparam int PB_PARITY_EN = 2;
  localparam int PB_SPEAKER = 1;
  localparam int PB_TIMER2_GATE = 0;
  localparam logic [3:0] PB_CTRL_RESET = 4'h0;
  localparam int NMI_MASK_BIT = 7;

  localparam int ST_NMI_EN = 0;
  localparam int ST_STALL_LATCH = 1;
  localparam int ST_NP_INT = 2;
  localparam int ST_MODE_ACTIVE = 3;

  typedef enum logic [2:0] {
    CBSC_SYNC_FULL = 3'b000,
    CBSC_SYNC_NORMAL = 3'b001,
    CBSC_SYNC_HALF = 3'b010,
    CBSC_ASYNC_FAST = 3'b011,
    CBSC_ASYNC_BUS = 3'b100
  } cbsc_mode_t;

  typedef enum logic [1:0] {
    CBSC_SRC_FAST = 2'b00,
    CBSC_SRC_HALF = 2'b01,
    CBSC_SRC_BUS = 2'b10
  } cbsc_src_t;

  typedef enum logic [1:0] {
    CBSC_OWN_IDLE = 2'b00,
    CBSC_OWN_CPU = 2'b01,
    CBSC_OWN_DMA = 2'b10,
    CBSC_OWN_REFRESH = 2'b11
  } cbsc_own_t;

  typedef enum logic [1:0] {
    CBSC_BUS_IDLE = 2'b00,
    CBSC_BUS_ADDR = 2'b01,
    CBSC_BUS_CMD = 2'b10,
    CBSC_BUS_END = 2'b11
  } cbsc_bus_t;

  typedef enum logic {
    CBSC_PH_ONE = 1'b0,
    CBSC_PH_TWO = 1'b1
  } cbsc_phase_t;
endpackage

// File: cbsc_top.sv
// The implementer's own choices: the strobed register port and the register addresses.
`timescale 1ns/1ps
module cbsc_top #(
  parameter int COLD_CYC = cbsc_pkg::COLD_RESET_CYC,
  parameter int WARM_CYC = cbsc_pkg::WARM_RESET_CYC,
  parameter int NP_CYC = cbsc_pkg::NP_RESET_CYC
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic [7:0] io_addr,
  input wire logic [7:0] io_wdata,
  input wire logic io_wr,
  input wire logic io_rd,
  output logic [7:0] io_rdata,
  input wire logic warm_reset_req,
  output logic system_reset,
  output logic cpu_reset,
  input wire logic fast_clock_input,
  input wire logic bus_clock_input,
  output logic cpu_clock,
  output logic cpu_phase_clock,
  output logic bus_state_clock,
  output logic expansion_bus_clock,
  input wire logic cpu_bus_req,
  input wire logic dma_req,
  input wire logic refresh_req,
  output logic cpu_grant,
  output logic dma_grant,
  output logic refresh_grant,
  input wire logic bus_cycle_req,
  output logic bus_cycle_done,
  input wire logic io_check_source,
  input wire logic parity_check_source,
  input wire logic timer2_output,
  input wire logic refresh_toggle,
  output logic timer2_gate,
  output logic speaker_data,
  output logic nmi,
  output logic coprocessor_select,
  input wire logic coprocessor_active_in,
  input wire logic coprocessor_fault_in,
  output logic cpu_stall_out,
  output logic coprocessor_interrupt,
  output logic coprocessor_reset
);
  function automatic cbsc_pkg::cbsc_src_t cpu_src(
    input cbsc_pkg::cbsc_mode_t m
  );
    unique case (m)
      cbsc_pkg::CBSC_SYNC_HALF: cpu_src = cbsc_pkg::CBSC_SRC_HALF;
      cbsc_pkg::CBSC_ASYNC_BUS: cpu_src = cbsc_pkg::CBSC_SRC_BUS;
      default: cpu_src = cbsc_pkg::CBSC_SRC_FAST;
    endcase
  endfunction

  function automatic cbsc_pkg::cbsc_src_t bus_src(
    input cbsc_pkg::cbsc_mode_t m
  );
    unique case (m)
      cbsc_pkg::CBSC_SYNC_FULL: bus_src = cbsc_pkg::CBSC_SRC_FAST;
      cbsc_pkg::CBSC_ASYNC_FAST,
      cbsc_pkg::CBSC_ASYNC_BUS: bus_src = cbsc_pkg::CBSC_SRC_BUS;
      default: bus_src = cbsc_pkg::CBSC_SRC_HALF;
    endcase
  endfunction

  function automatic logic pick(
    input cbsc_pkg::cbsc_src_t s,
    input logic f,
    input logic h,
    input logic b
  );
    unique case (s)
      cbsc_pkg::CBSC_SRC_HALF: pick = h;
      cbsc_pkg::CBSC_SRC_BUS: pick = b;
      default: pick = f;
    endcase
  endfunction

  function automatic logic legal_mode(input logic [2:0] v);
    legal_mode = (v <= 3'(cbsc_pkg::CBSC_ASYNC_BUS));
  endfunction

  // ---------------- register port decode
  wire wr_portb = io_wr && (io_addr == cbsc_pkg::PORTB_ADDR);
  wire wr_nmi = io_wr && (io_addr == cbsc_pkg::NMI_MASK_ADDR);
  wire wr_np_clr = io_wr && (io_addr == cbsc_pkg::NP_CLEAR_ADDR);
  wire wr_np_rst = io_wr && (io_addr == cbsc_pkg::NP_RESET_ADDR);
  wire wr_clk = io_wr && (io_addr == cbsc_pkg::CLK_CFG_ADDR);
  wire np_reg_hit =
    (io_addr & cbsc_pkg::NP_REG_MASK) == cbsc_pkg::NP_REG_BASE;

  // select follows the address combinationally while a strobe is up
  assign coprocessor_select = (io_wr || io_rd) &&
    (np_reg_hit || io_addr == cbsc_pkg::NMI_MASK_ADDR ||
     io_addr == cbsc_pkg::NP_CLEAR_ADDR); // see R16

  // ---------------- resets
  logic [cbsc_pkg::RST_CNT_W-1:0] cold_cnt;
  logic [cbsc_pkg::RST_CNT_W-1:0] warm_cnt;
  logic [cbsc_pkg::RST_CNT_W-1:0] np_cnt;
  logic sys_rst_q;
  wire [cbsc_pkg::RST_CNT_W-1:0] cold_load = cbsc_pkg::RST_CNT_W'(COLD_CYC);
  wire [cbsc_pkg::RST_CNT_W-1:0] warm_load = cbsc_pkg::RST_CNT_W'(WARM_CYC);
  wire [cbsc_pkg::RST_CNT_W-1:0] np_load = cbsc_pkg::RST_CNT_W'(NP_CYC);
  wire cold_busy = (cold_cnt != '0);

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      cold_cnt <= cold_load; // see R01
      sys_rst_q <= 1'b1;
    end else begin
      sys_rst_q <= cold_busy; // see R01
      if (cold_busy) begin
        cold_cnt <= cold_cnt - 1'b1;
      end
    end
  end

  // warm reset touches only the cpu counter
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      warm_cnt <= '0;
    end else if (warm_reset_req) begin
      warm_cnt <= warm_load; // see R02
    end else if (warm_cnt != '0) begin
      warm_cnt <= warm_cnt - 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      np_cnt <= '0;
    end else if (wr_np_rst) begin
      np_cnt <= np_load; // see R21
    end else if (np_cnt != '0) begin
      np_cnt <= np_cnt - 1'b1;
    end
  end

  assign system_reset = sys_rst_q; // see R01
  assign cpu_reset = sys_rst_q || (warm_cnt != '0); // see R02
  assign coprocessor_reset = sys_rst_q || (np_cnt != '0); // see R21

  // ---------------- clock generation
  // sources are sampled, so generated clocks are at most sys_clk/2
  logic fast_q;
  logic bus_q;
  logic fast_half;
  cbsc_pkg::cbsc_mode_t mode_req;
  cbsc_pkg::cbsc_mode_t mode_act;
  wire fast_rise = fast_clock_input && !fast_q;
  wire cpu_next_lvl = pick(cpu_src(mode_act), fast_q, fast_half, bus_q);
  wire bus_next_lvl = pick(bus_src(mode_act), fast_q, fast_half, bus_q);
  // switch only while every source and the cpu and bus state clocks are low: no runts
  wire quiet = !fast_q && !fast_half && !bus_q &&
    !cpu_clock && !bus_state_clock; // see R23

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      fast_q <= 1'b0;
      bus_q <= 1'b0;
      fast_half <= 1'b0;
    end else begin
      fast_q <= fast_clock_input;
      bus_q <= bus_clock_input;
      if (fast_rise) begin
        fast_half <= !fast_half; // see R07
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      mode_req <= cbsc_pkg::CBSC_SYNC_NORMAL; // see R22
      mode_act <= cbsc_pkg::CBSC_SYNC_NORMAL; // see R22
    end else begin
      if (wr_clk && legal_mode(io_wdata[2:0])) begin
        mode_req <= cbsc_pkg::cbsc_mode_t'(io_wdata[2:0]);
      end
      if (quiet) begin
        mode_act <= mode_req; // see R23
      end
    end
  end

  // sync modes feed both from fast input, async take the bus state clock from bus input
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      cpu_clock <= 1'b0;
      bus_state_clock <= 1'b0;
    end else begin
      cpu_clock <= cpu_next_lvl; // see R05 R06 R07 R08
      bus_state_clock <= bus_next_lvl; // see R05 R06 R07 R08
    end
  end

  wire cpu_rise = cpu_next_lvl && !cpu_clock;
  wire bus_rise = bus_next_lvl && !bus_state_clock;

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      expansion_bus_clock <= 1'b0;
    end else if (bus_rise) begin
      expansion_bus_clock <= !expansion_bus_clock; // see R04 R08
    end
  end

  // ---------------- cpu state machine, runs off cpu clock edges
  cbsc_pkg::cbsc_phase_t cpu_state;
  always_ff @(posedge sys_clk) begin
    if (srst || cpu_reset) begin
      cpu_state <= cbsc_pkg::CBSC_PH_ONE;
    end else if (cpu_rise) begin
      unique case (cpu_state)
        cbsc_pkg::CBSC_PH_ONE: cpu_state <= cbsc_pkg::CBSC_PH_TWO;
        cbsc_pkg::CBSC_PH_TWO: cpu_state <= cbsc_pkg::CBSC_PH_ONE;
      endcase // see R10
    end
  end
  assign cpu_phase_clock = (cpu_state == cbsc_pkg::CBSC_PH_TWO); // see R03

  // ---------------- bus state machine, runs off bus state clock edges
  cbsc_pkg::cbsc_bus_t bus_state;
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      bus_state <= cbsc_pkg::CBSC_BUS_IDLE;
    end else if (bus_rise) begin
      unique case (bus_state)
        cbsc_pkg::CBSC_BUS_IDLE: begin
          if (bus_cycle_req && cpu_grant) begin
            bus_state <= cbsc_pkg::CBSC_BUS_ADDR; // see R10
          end
        end
        cbsc_pkg::CBSC_BUS_ADDR: bus_state <= cbsc_pkg::CBSC_BUS_CMD;
        cbsc_pkg::CBSC_BUS_CMD: bus_state <= cbsc_pkg::CBSC_BUS_END;
        cbsc_pkg::CBSC_BUS_END: bus_state <= cbsc_pkg::CBSC_BUS_IDLE;
      endcase
    end
  end
  assign bus_cycle_done = bus_rise &&
    (bus_state == cbsc_pkg::CBSC_BUS_END);

  // ---------------- bus ownership
  // refresh first: a missed refresh corrupts memory, a late dma does not
  cbsc_pkg::cbsc_own_t owner;
  cbsc_pkg::cbsc_own_t next_owner;
  wire owner_req = (owner == cbsc_pkg::CBSC_OWN_CPU && cpu_bus_req) ||
    (owner == cbsc_pkg::CBSC_OWN_DMA && dma_req) ||
    (owner == cbsc_pkg::CBSC_OWN_REFRESH && refresh_req);
  wire bus_cycle_open = (bus_state != cbsc_pkg::CBSC_BUS_IDLE);

  always_comb begin
    next_owner = owner;
    if (!owner_req && !bus_cycle_open) begin
      if (refresh_req) begin
        next_owner = cbsc_pkg::CBSC_OWN_REFRESH; // see R11
      end else if (dma_req) begin
        next_owner = cbsc_pkg::CBSC_OWN_DMA; // see R11
      end else if (cpu_bus_req) begin
        next_owner = cbsc_pkg::CBSC_OWN_CPU; // see R11
      end else begin
        next_owner = cbsc_pkg::CBSC_OWN_IDLE;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      owner <= cbsc_pkg::CBSC_OWN_IDLE;
    end else begin
      owner <= next_owner;
    end
  end
  assign cpu_grant = (owner == cbsc_pkg::CBSC_OWN_CPU);
  assign dma_grant = (owner == cbsc_pkg::CBSC_OWN_DMA);
  assign refresh_grant = (owner == cbsc_pkg::CBSC_OWN_REFRESH);

  // ---------------- port b and nmi
  logic [3:0] pb_ctrl;
  logic parity_flag;
  logic channel_flag;
  logic nmi_enable;
  wire chan_en = pb_ctrl[cbsc_pkg::PB_CHANNEL_EN];
  wire par_en = pb_ctrl[cbsc_pkg::PB_PARITY_EN];
  wire next_chan_en = wr_portb ? io_wdata[cbsc_pkg::PB_CHANNEL_EN] : chan_en;
  wire next_par_en = wr_portb ? io_wdata[cbsc_pkg::PB_PARITY_EN] : par_en;

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      pb_ctrl <= cbsc_pkg::PB_CTRL_RESET;
      nmi_enable <= 1'b0;
    end else begin
      if (wr_portb) begin
        pb_ctrl <= io_wdata[3:0]; // see R12
      end
      if (wr_nmi) begin
        nmi_enable <= !io_wdata[cbsc_pkg::NMI_MASK_BIT]; // see R15
      end
    end
  end

  // dropping an enable clears its flag; a new error in that cycle wins
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      parity_flag <= 1'b0;
      channel_flag <= 1'b0;
    end else begin
      parity_flag <= (parity_check_source && par_en) ||
        (parity_flag && next_par_en); // see R13
      channel_flag <= (io_check_source && chan_en) ||
        (channel_flag && next_chan_en); // see R13
    end
  end
  assign nmi = nmi_enable && (parity_flag || channel_flag); // see R13
  assign speaker_data = pb_ctrl[cbsc_pkg::PB_SPEAKER];
  assign timer2_gate = pb_ctrl[cbsc_pkg::PB_TIMER2_GATE];

  // ---------------- coprocessor busy and fault
  logic stall_latch;
  wire np_clear = wr_np_clr || wr_np_rst;
  wire fault_set = coprocessor_active_in && coprocessor_fault_in;

  always_ff @(posedge sys_clk) begin
    if (srst || sys_rst_q) begin
      stall_latch <= 1'b0; // see R20
    end else if (fault_set) begin
      stall_latch <= 1'b1; // see R18
    end else if (np_clear) begin
      stall_latch <= 1'b0; // see R19
    end
  end
  assign cpu_stall_out = coprocessor_active_in || stall_latch; // see R17 R18
  assign coprocessor_interrupt = stall_latch; // see R18 R19

  // ---------------- read data, one cycle after the strobe
  logic [7:0] portb_view;
  logic [7:0] status_view;
  logic [7:0] next_rdata;

  // field positions live in the package so the map stays in one place
  always_comb begin
    portb_view = {4'h0, pb_ctrl}; // see R12
    portb_view[cbsc_pkg::PB_PARITY_FLAG] = parity_flag; // see R14
    portb_view[cbsc_pkg::PB_CHANNEL_FLAG] = channel_flag; // see R14
    portb_view[cbsc_pkg::PB_TIMER2_OUT] = timer2_output;
    portb_view[cbsc_pkg::PB_REFRESH] = refresh_toggle;
    status_view = 8'h00;
    status_view[cbsc_pkg::ST_NMI_EN] = nmi_enable;
    status_view[cbsc_pkg::ST_STALL_LATCH] = stall_latch;
    status_view[cbsc_pkg::ST_NP_INT] = stall_latch;
    status_view[cbsc_pkg::ST_MODE_ACTIVE] = (mode_act == mode_req);
  end

  always_comb begin
    next_rdata = 8'h00;
    if (io_rd) begin
      unique case (io_addr)
        cbsc_pkg::PORTB_ADDR: next_rdata = portb_view; // see R14
        cbsc_pkg::CLK_CFG_ADDR: next_rdata = {5'h00, mode_req};
        cbsc_pkg::STATUS_ADDR: next_rdata = status_view;
        default: next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      io_rdata <= 8'h00;
    end else begin
      io_rdata <= next_rdata;
    end
  end
endmodule

// File: cbsc_top_bench.sv
`timescale 1ns/1ps
module cbsc_top_bench;
  localparam int COLD = 4;
  localparam int WARM = 2;
  localparam int NP = 2;
  logic sys_clk = 1'b0, srst = 1'b1, io_wr = 1'b0, io_rd = 1'b0;
  logic [7:0] io_addr = 8'h00, io_wdata = 8'h00, io_rdata, busy_len = 8'h00;
  logic warm_reset_req = 1'b0, fast_clock_input = 1'b0, dma_req = 1'b0;
  logic bus_clock_input = 1'b0, cpu_bus_req = 1'b0, refresh_req = 1'b0;
  logic bus_cycle_req = 1'b0, io_check_source = 1'b0, start = 1'b0;
  logic parity_check_source = 1'b0, timer2_output = 1'b0, rd_d = 1'b0;
  logic refresh_toggle = 1'b0, fault_req = 1'b0;
  logic system_reset, cpu_reset, cpu_clock, cpu_phase_clock, bus_state_clock;
  logic expansion_bus_clock, cpu_grant, dma_grant, refresh_grant, nmi;
  logic bus_cycle_done, timer2_gate, speaker_data, coprocessor_select;
  logic coprocessor_active_in, coprocessor_fault_in, cpu_stall_out;
  logic coprocessor_interrupt, coprocessor_reset;
  logic [7:0] exp_q[$];
  logic [7:0] d;
  logic [7:0] al [10] = '{8'hf8, 8'hfb, 8'hff, 8'h70, 8'hf0, 8'hf1, 8'hf7,
    8'h71, 8'h00, 8'h60};
  logic [1:0] fc = 2'h0;
  logic [2:0] bc = 3'h0;
  wire [3:0] clks = {cpu_clock, bus_state_clock, expansion_bus_clock,
    cpu_phase_clock};
  int fail_count = 0, cmp_count = 0, n;
  cbsc_top #(.COLD_CYC(COLD), .WARM_CYC(WARM), .NP_CYC(NP)) cbsc_top_inst (
    .sys_clk(sys_clk), .srst(srst), .io_addr(io_addr), .io_wdata(io_wdata),
    .io_wr(io_wr), .io_rd(io_rd), .io_rdata(io_rdata),
    .warm_reset_req(warm_reset_req), .system_reset(system_reset),
    .cpu_reset(cpu_reset), .fast_clock_input(fast_clock_input),
    .bus_clock_input(bus_clock_input), .cpu_clock(cpu_clock),
    .cpu_phase_clock(cpu_phase_clock), .bus_state_clock(bus_state_clock),
    .expansion_bus_clock(expansion_bus_clock), .cpu_bus_req(cpu_bus_req),
    .dma_req(dma_req), .refresh_req(refresh_req), .cpu_grant(cpu_grant),
    .dma_grant(dma_grant), .refresh_grant(refresh_grant),
    .bus_cycle_req(bus_cycle_req), .bus_cycle_done(bus_cycle_done),
    .io_check_source(io_check_source), .timer2_gate(timer2_gate),
    .parity_check_source(parity_check_source), .nmi(nmi),
    .timer2_output(timer2_output), .refresh_toggle(refresh_toggle),
    .speaker_data(speaker_data), .coprocessor_select(coprocessor_select),
    .coprocessor_active_in(coprocessor_active_in),
    .coprocessor_fault_in(coprocessor_fault_in),
    .cpu_stall_out(cpu_stall_out), .coprocessor_reset(coprocessor_reset),
    .coprocessor_interrupt(coprocessor_interrupt));
  cbsc_copro_model cbsc_copro_model_inst (.sys_clk(sys_clk),
    .coprocessor_reset(coprocessor_reset), .busy_len(busy_len),
    .start(start), .fault_req(fault_req),
    .coprocessor_active_in(coprocessor_active_in),
    .coprocessor_fault_in(coprocessor_fault_in));
  initial forever #10 sys_clk = ~sys_clk;
  // input clocks kept below half of sys_clk so they can be reproduced
  always @(posedge sys_clk) begin
    fc <= fc + 2'h1;
    bc <= (bc == 3'h5) ? 3'h0 : bc + 3'h1;
    fast_clock_input <= fc[1];
    bus_clock_input <= bc < 3'h3;
  end
  always @(posedge sys_clk) begin
    if (rd_d) check(io_rdata, exp_q.pop_front());
    rd_d <= io_rd;
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    cmp_count++;
    if (seen !== want) begin
      fail_count++;
      $display("ERROR %0t: saw %h want %h", $time, seen, want);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge sys_clk);
  endtask
  // 24 cycles hold whole periods of the 4, 8 and 6 cycle sources
  task automatic clk_cnt(input int ec, input int eb);
    int c[4] = '{0, 0, 0, 0};
    logic [3:0] p;
    logic [3:0] v;
    #1 v = clks;
    repeat (24) begin
      p = v;
      @(posedge sys_clk);
      #1 v = clks;
      c[0] += int'(v[3] && !p[3]);
      c[1] += int'(v[2] && !p[2]);
      c[2] += int'(v[1] != p[1]);
      c[3] += int'(v[0] != p[0]);
    end
    check(8'(c[0]), 8'(ec));
    check(8'(c[1]), 8'(eb));
    check(8'(c[2]), 8'(eb));
    check(8'(c[3]), 8'(ec));
  endtask
  function automatic logic [7:0] sel(input logic [7:0] a);
    return {7'h00, a[7:3] == 5'h1f || a == 8'h70 || a == 8'hf0};
  endfunction
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge sys_clk);
    io_addr <= a;
    io_wdata <= v;
    io_wr <= 1'b1;
    #1 check(coprocessor_select, sel(a));
    @(posedge sys_clk);
    io_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    @(posedge sys_clk);
    io_addr <= a;
    io_rd <= 1'b1;
    #1 check(coprocessor_select, sel(a));
    @(posedge sys_clk);
    io_rd <= 1'b0;
  endtask
  task automatic fault_run();
    busy_len <= 8'h0a;
    start <= 1'b1;
    cyc(1);
    start <= 1'b0;
    cyc(2);
    #1 check(cpu_stall_out, 1'b1);
    check(coprocessor_interrupt, 1'b0);
    cyc(1);
    fault_req <= 1'b1;
    cyc(1);
    fault_req <= 1'b0;
    cyc(15);
    #1 check(coprocessor_interrupt, 1'b1);
    check(cpu_stall_out, 1'b1);
  endtask
  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    void'($urandom(5));
    cyc(20);
    srst <= 1'b0;
    cyc(1);
    #1 check(system_reset, 1'b1);
    check(coprocessor_reset, 1'b1);
    cyc(COLD + 3);
    #1 check(system_reset, 1'b0);
    check(cpu_reset, 1'b0);
    rd(8'h0c, 8'h01);
    clk_cnt(6, 3);
    for (int m = 0; m < 5; m++) begin
      wr(8'h0c, 8'(m));
      cyc(40);
      rd(8'h0c, 8'(m));
      clk_cnt(m == 2 ? 3 : m == 4 ? 4 : 6,
        m == 0 ? 6 : m < 3 ? 3 : 4);
    end
    wr(8'h0c, 8'h05);
    rd(8'h0c, 8'h04);
    rd(8'h33, 8'h00);
    wr(8'h0c, 8'h01);
    for (int i = 0; i < 4; i++) begin
      d = 8'($urandom) & 8'hf3;
      wr(8'h61, d);
      timer2_output <= 1'($urandom);
      refresh_toggle <= 1'($urandom);
      #1 check(speaker_data, d[1]);
      check(timer2_gate, d[0]);
      rd(8'h61, {2'b00, timer2_output, refresh_toggle, d[3:0]});
    end
    foreach (al[i]) wr(al[i], 8'h80);
    wr(8'h70, 8'h00);
    wr(8'h61, 8'h08);
    io_check_source <= 1'b1;
    cyc(1);
    io_check_source <= 1'b0;
    cyc(2);
    #1 check(nmi, 1'b1);
    rd(8'h61, {2'b01, timer2_output, refresh_toggle, 4'h8});
    wr(8'h70, 8'h80);
    #1 check(nmi, 1'b0);
    wr(8'h70, 8'h00);
    #1 check(nmi, 1'b1);
    wr(8'h61, 8'h04);
    parity_check_source <= 1'b1;
    cyc(1);
    parity_check_source <= 1'b0;
    cyc(2);
    rd(8'h61, {2'b10, timer2_output, refresh_toggle, 4'h4});
    wr(8'h61, 8'h00);
    #1 check(nmi, 1'b0);
    for (int k = 0; k < 2; k++) begin
      cyc(1);
      fault_run();
      wr(8'hf0 + 8'(k), 8'h00);
      #1 check(coprocessor_interrupt, 1'b0);
      check(cpu_stall_out, 1'b0);
      check(coprocessor_reset, 8'(k));
    end
    cyc(NP + 1);
    #1 check(coprocessor_reset, 1'b0);
    cyc(1);
    warm_reset_req <= 1'b1;
    cyc(1);
    warm_reset_req <= 1'b0;
    cyc(1);
    #1 check(cpu_reset, 1'b1);
    check(system_reset, 1'b0);
    cyc(WARM + 2);
    #1 check(cpu_reset, 1'b0);
    cyc(1);
    dma_req <= 1'b1;
    cpu_bus_req <= 1'b1;
    cyc(3);
    #1 check(dma_grant, 1'b1);
    cyc(1);
    dma_req <= 1'b0;
    cyc(3);
    #1 check(cpu_grant, 1'b1);
    cyc(1);
    bus_cycle_req <= 1'b1;
    n = 0;
    while (bus_cycle_done !== 1'b1 && n < 200) begin
      cyc(1);
      #1 n++;
    end
    check(bus_cycle_done, 1'b1);
    cyc(1);
    bus_cycle_req <= 1'b0;
    cpu_bus_req <= 1'b0;
    refresh_req <= 1'b1;
    cyc(3);
    #1 check(refresh_grant, 1'b1);
    cyc(1);
    refresh_req <= 1'b0;
    fault_run();
    rd(8'h0d, 8'h0f);
    cyc(1);
    srst <= 1'b1;
    cyc(2);
    srst <= 1'b0;
    cyc(1);
    #1 check(coprocessor_interrupt, 1'b0);
    check(system_reset, 1'b1);
    report_and_stop();
  end
  initial begin
    cyc(20000);
    fail_count++;
    report_and_stop();
  end
endmodule
bind cbsc_top cbsc_monitor #(.NP_CYC(NP_CYC)) cbsc_monitor_inst (
  .sys_clk(sys_clk), .srst(srst), .io_addr(io_addr), .io_wdata(io_wdata),
  .io_wr(io_wr), .io_rd(io_rd), .warm_reset_req(warm_reset_req),
  .system_reset(system_reset), .cpu_reset(cpu_reset), .nmi(nmi),
  .cpu_clock(cpu_clock), .cpu_phase_clock(cpu_phase_clock),
  .bus_state_clock(bus_state_clock), .cpu_grant(cpu_grant),
  .expansion_bus_clock(expansion_bus_clock), .dma_grant(dma_grant),
  .refresh_grant(refresh_grant), .timer2_gate(timer2_gate),
  .speaker_data(speaker_data), .coprocessor_select(coprocessor_select),
  .coprocessor_active_in(coprocessor_active_in),
  .coprocessor_fault_in(coprocessor_fault_in),
  .cpu_stall_out(cpu_stall_out), .coprocessor_reset(coprocessor_reset),
  .coprocessor_interrupt(coprocessor_interrupt));
